/* File: bus_far_model.sv */
// far side: four monitored differential pairs as the receivers see them
// bench calls put at a rising edge; released pairs toggle, never hold a stale level
`timescale 1ns/1ns
module bus_far_model (
  input wire clk_sys,
  output reg [3:0] rx_level = 4'h0,
  output reg [3:0] rx_invalid = 4'hF
);
  reg [3:0] drv = 4'h0; // pairs being driven
  reg [3:0] lvl = 4'h0; // their levels
  // new bus state from the bench
  task put(input [3:0] d, input [3:0] l);
    begin
      drv <= d;
      lvl <= l;
    end
  endtask
  // pair wired plus to plus, so the level arrives uninverted
  always @(posedge clk_sys) begin
    rx_invalid <= ~drv;
    rx_level <= (lvl & drv) | (~rx_level & ~drv);
  end
endmodule // bus_far_model

/* File: bus_tap_defs.vh */
// constants for the bus tap signal router: connection modes, aux pin selections, timing
// assumes a single 125 MHz system clock; included by bare name
`ifndef BUS_TAP_DEFS_VH
`define BUS_TAP_DEFS_VH

// connection modes (wiring)
`define MODE_TAP2 2'h0
`define MODE_SEG2 2'h1
`define MODE_TAP4 2'h2
`define MODE_SEG4 2'h3

// aux pin selections
`define AUX_IN_PD 4'h0
`define AUX_IN_PU 4'h1
`define AUX_OUT_LO 4'h2
`define AUX_OUT_HI 4'h3
`define AUX_OUT_DIR 4'h4
`define AUX_OUT_BUSACT 4'h5
`define AUX_OUT_ACT1 4'h6
`define AUX_OUT_ACT2 4'h7
`define AUX_OUT_ACT3 4'h8
`define AUX_OUT_ACT4 4'h9
`define AUX_OUT_ERR 4'hA

// timing
`define CLK_MHZ 125
`define STAMP_US 1
`define STAMP_CYC (`STAMP_US * `CLK_MHZ)
`define BIT_CYC_DEFAULT 16'h043D

// fifo
`define FIFO_DEPTH 8
`define REC_WIDTH 32

`endif

/* File: bus_tap_signal_router.v */
// bus tap signal router: samples four receivers, routes two to decoders,
// derives direction/merged signals, drives two aux pins, records line changes.
// assumes receiver outputs (data + invalid) are synchronous to clk_sys.
`timescale 1ns/1ns
`include "bus_tap_defs.vh"

// change-record fifo, width and depth parameterised
module rec_fifo #(
  parameter WIDTH = `REC_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
  reg [AW-1:0] wr_reg; // write pointer
  reg [AW-1:0] rd_reg; // read pointer
  reg [AW:0] cnt_reg; // words held in mem
  wire push;
  wire pop;
  wire out_take;

  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_take = ~out_valid | out_ready;
  assign pop = out_take & (cnt_reg != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;

  // pointers, count and registered head
  // storage has no reset: only pointers, count and head need a known start
  always @(posedge clk_sys) begin
    if (clk_en && push)
      mem[wr_reg] <= in_data;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_reg];
        rd_reg <= rd_reg + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0; // head consumed, nothing behind it
      end
      if (push & ~pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // rec_fifo

module bus_tap_signal_router #(
  parameter MODE_W = 2,
  parameter SEL_W = 4,
  parameter STAMP_W = 22, // at least the 22-bit stamp field of a record
  parameter BIT_W = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [3:0] rx_level, // receiver logic level, inputs one..four
  input wire [3:0] rx_invalid, // receiver reports tri-state level
  input wire [MODE_W-1:0] conn_mode, // active connection mode
  input wire [SEL_W-1:0] aux_sel_0, // selection for aux pin 0
  input wire [SEL_W-1:0] aux_sel_1, // selection for aux pin 1
  input wire [BIT_W-1:0] bit_cycles, // one bit time in clocks
  input wire [1:0] dec_error, // framing/parity/break pulses from decoders
  input wire [1:0] aux_in, // aux pin input levels
  input wire rec_ready, // recording path accepts a record
  output reg dec_a_rx, // serial line to decoder A
  output reg dec_b_rx, // serial line to decoder B
  output reg [3:0] line_state, // recorded logic state per input
  output reg [3:0] line_active, // driven flag per input
  output reg dir_val, // direction, mark = two to one
  output reg dir_invalid, // direction invalid (bus undriven)
  output reg merged_val, // forwarded bus level
  output reg merged_invalid, // no data on either segment
  output reg fwd_one_out, // drive level toward segment one
  output reg fwd_one_oe_n, // low while driving segment one
  output reg fwd_two_out, // drive level toward segment two
  output reg fwd_two_oe_n, // low while driving segment two
  output reg [1:0] aux_out, // aux pin drive level
  output reg [1:0] aux_oe_n, // low while aux pin drives
  output reg [1:0] aux_pull_up, // 1 pull-up, 0 pull-down when input
  output reg [1:0] aux_rec, // recorded aux input states
  output reg rec_valid, // record available
  output reg [`REC_WIDTH-1:0] rec_data // {aux, active, level, stamp}
);
  localparam [7:0] STAMP_CYC = `STAMP_CYC;

  reg [3:0] lvl_reg; // sampled levels
  reg [3:0] inv_reg; // sampled invalid flags
  reg [7:0] us_cnt_reg; // clocks within one microsecond
  reg [STAMP_W-1:0] stamp_reg; // microsecond time stamp
  reg [1:0] owner_reg; // 0 none, 1 segment one drives, 2 segment two
  reg [1:0] aux_in_reg; // sampled aux inputs
  reg [BIT_W-1:0] err_cnt_reg; // remaining error pulse clocks
  reg [9:0] prev_reg; // last recorded snapshot
  reg [1:0] owner_next;
  reg err_active;
  wire [9:0] snap;
  wire snap_change;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`REC_WIDTH-1:0] fifo_out_data;
  wire fifo_take;

  // aux pin drive decode, shared by both pins
  function aux_drive;
    input [SEL_W-1:0] sel;
    input dir_bit;
    input bus_act;
    input [3:0] act;
    input err;
    begin
      case (sel)
        `AUX_OUT_HI: aux_drive = 1'b1;
        `AUX_OUT_DIR: aux_drive = dir_bit;
        `AUX_OUT_BUSACT: aux_drive = bus_act;
        `AUX_OUT_ACT1: aux_drive = act[0];
        `AUX_OUT_ACT2: aux_drive = act[1];
        `AUX_OUT_ACT3: aux_drive = act[2];
        `AUX_OUT_ACT4: aux_drive = act[3];
        `AUX_OUT_ERR: aux_drive = err;
        default: aux_drive = 1'b0;
      endcase
    end
  endfunction

  // aux pin acts as input only for pull selections
  function aux_is_input;
    input [SEL_W-1:0] sel;
    begin
      aux_is_input = (sel == `AUX_IN_PD) || (sel == `AUX_IN_PU);
    end
  endfunction

  // forwarding ownership: first segment to leave tri-state wins until idle
  always @* begin
    owner_next = owner_reg;
    if (owner_reg == 2'h1 && inv_reg[0])
      owner_next = 2'h0;
    else if (owner_reg == 2'h2 && inv_reg[1])
      owner_next = 2'h0;
    if (owner_next == 2'h0) begin
      if (!inv_reg[0])
        owner_next = 2'h1;
      else if (!inv_reg[1])
        owner_next = 2'h2;
    end
  end

  always @* begin
    err_active = (err_cnt_reg != {BIT_W{1'b0}});
  end

  assign snap = {aux_in_reg, ~inv_reg, lvl_reg};
  assign snap_change = (snap != prev_reg);
  assign fifo_take = ~rec_valid | rec_ready;

  // sampling, routing, status and pins
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvl_reg <= 4'hF;
      inv_reg <= 4'hF;
      us_cnt_reg <= 8'h00;
      stamp_reg <= {STAMP_W{1'b0}};
      owner_reg <= 2'h0;
      aux_in_reg <= 2'h0;
      err_cnt_reg <= {BIT_W{1'b0}};
      prev_reg <= 10'h00F; // matches the reset snapshot, so no false record
      dec_a_rx <= 1'b1;
      dec_b_rx <= 1'b1;
      line_state <= 4'h0;
      line_active <= 4'h0;
      dir_val <= 1'b0;
      dir_invalid <= 1'b1;
      merged_val <= 1'b1;
      merged_invalid <= 1'b1;
      fwd_one_out <= 1'b1;
      fwd_one_oe_n <= 1'b1;
      fwd_two_out <= 1'b1;
      fwd_two_oe_n <= 1'b1;
      aux_out <= 2'h0;
      aux_oe_n <= 2'h3;
      aux_pull_up <= 2'h0;
      aux_rec <= 2'h0;
      rec_valid <= 1'b0;
      rec_data <= {`REC_WIDTH{1'b0}};
    end else if (clk_en) begin
      lvl_reg <= rx_level;
      inv_reg <= rx_invalid;
      aux_in_reg <= aux_in;
      line_state <= lvl_reg;
      line_active <= ~inv_reg;
      aux_rec <= aux_in_reg;
      // microsecond time base
      if (us_cnt_reg == STAMP_CYC - 8'h01) begin
        us_cnt_reg <= 8'h00;
        stamp_reg <= stamp_reg + 1'b1;
      end else begin
        us_cnt_reg <= us_cnt_reg + 8'h01;
      end
      owner_reg <= owner_next;
      // decoder routing per mode
      case (conn_mode)
        `MODE_SEG2: begin
          dec_a_rx <= lvl_reg[0];
          dec_b_rx <= lvl_reg[1];
        end
        `MODE_SEG4: begin
          // merged halves on A, tapped master bus on B
          dec_a_rx <= (owner_next == 2'h2) ? lvl_reg[1] : lvl_reg[0];
          dec_b_rx <= lvl_reg[2];
        end
        `MODE_TAP4: begin
          dec_a_rx <= lvl_reg[0];
          dec_b_rx <= lvl_reg[1];
        end
        default: begin
          dec_a_rx <= lvl_reg[0];
          dec_b_rx <= lvl_reg[1];
        end
      endcase
      // bidirectional forwarding only in segment modes
      if (conn_mode == `MODE_SEG2 || conn_mode == `MODE_SEG4) begin
        fwd_two_oe_n <= ~(owner_next == 2'h1);
        fwd_two_out <= lvl_reg[0];
        fwd_one_oe_n <= ~(owner_next == 2'h2);
        fwd_one_out <= lvl_reg[1];
      end else begin
        fwd_one_oe_n <= 1'b1;
        fwd_two_oe_n <= 1'b1;
      end
      dir_val <= (owner_next == 2'h2);
      dir_invalid <= (owner_next == 2'h0);
      merged_val <= (owner_next == 2'h2) ? lvl_reg[1] : lvl_reg[0];
      merged_invalid <= (owner_next == 2'h0);
      // error pulse stretched to one bit time; new error restarts it
      if (dec_error != 2'h0)
        err_cnt_reg <= bit_cycles;
      else if (err_active)
        err_cnt_reg <= err_cnt_reg - 1'b1;
      // aux pins
      aux_oe_n[0] <= aux_is_input(aux_sel_0);
      aux_oe_n[1] <= aux_is_input(aux_sel_1);
      aux_pull_up[0] <= (aux_sel_0 == `AUX_IN_PU);
      aux_pull_up[1] <= (aux_sel_1 == `AUX_IN_PU);
      aux_out[0] <= aux_drive(aux_sel_0, owner_next == 2'h2, owner_next != 2'h0,
                              ~inv_reg, err_active);
      aux_out[1] <= aux_drive(aux_sel_1, owner_next == 2'h2, owner_next != 2'h0,
                              ~inv_reg, err_active);
      // change records; snapshot kept until the fifo accepts it
      if (snap_change && fifo_in_ready)
        prev_reg <= snap;
      if (fifo_take) begin
        rec_valid <= fifo_out_valid;
        rec_data <= fifo_out_data;
      end
    end
  end

  rec_fifo #(
    .WIDTH(`REC_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(snap_change),
    .in_ready(fifo_in_ready),
    .in_data({snap, stamp_reg[`REC_WIDTH-11:0]}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out_data)
  );
endmodule // bus_tap_signal_router

/* File: bus_tap_signal_router_asserts.sv */
// checker for the bus tap router: timing relations between receivers and outputs
// assumes one clock domain and the constants of bus_tap_defs.vh
`timescale 1ns/1ns
`include "bus_tap_defs.vh"
module router_chk #(
  parameter MODE_W = 2,
  parameter SEL_W = 4,
  parameter BIT_W = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [3:0] rx_level,
  input wire [3:0] rx_invalid,
  input wire [MODE_W-1:0] conn_mode,
  input wire [SEL_W-1:0] aux_sel_0,
  input wire [SEL_W-1:0] aux_sel_1,
  input wire [BIT_W-1:0] bit_cycles,
  input wire [1:0] dec_error,
  input wire rec_ready,
  input wire dec_a_rx,
  input wire dec_b_rx,
  input wire [3:0] line_state,
  input wire [3:0] line_active,
  input wire dir_val,
  input wire dir_invalid,
  input wire merged_val,
  input wire merged_invalid,
  input wire fwd_one_out,
  input wire fwd_one_oe_n,
  input wire fwd_two_out,
  input wire fwd_two_oe_n,
  input wire [1:0] aux_out,
  input wire [1:0] aux_oe_n,
  input wire [1:0] aux_pull_up,
  input wire rec_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // settled: five edges of quiet inputs outlast the two-edge pipeline
  sequence hold;
    (clk_en && $stable(rx_invalid) && $stable(rx_level & ~rx_invalid) && $stable(conn_mode)
      && $stable(aux_sel_0) && $stable(aux_sel_1))[*5];
  endsequence
  AST_ACTIVE: assert property (hold |-> line_active == ~rx_invalid)
    else $error("line_active wrong");
  AST_STATE: assert property (hold |-> ((line_state ^ rx_level) & ~rx_invalid) == 4'h0)
    else $error("line_state wrong");
  AST_DIR_INV: assert property (hold ##0 conn_mode[0] |-> dir_invalid == &rx_invalid[1:0])
    else $error("dir_invalid wrong");
  AST_DIR_VAL: assert property (hold ##0 conn_mode[0] && ^rx_invalid[1:0] |->
    dir_val == rx_invalid[0]) else $error("dir_val wrong");
  AST_MERGED: assert property (hold ##0 conn_mode[0] && ^rx_invalid[1:0] |->
    !merged_invalid && merged_val == (rx_invalid[0] ? rx_level[1] : rx_level[0]))
    else $error("merged wrong");
  AST_FWD: assert property (hold ##0 conn_mode[0] && ^rx_invalid[1:0] |-> (rx_invalid[0] ?
    !fwd_one_oe_n && fwd_one_out == rx_level[1] : !fwd_two_oe_n && fwd_two_out == rx_level[0]))
    else $error("forward wrong");
  AST_DEC_A: assert property (hold ##0 conn_mode != `MODE_SEG4 && !rx_invalid[0] |->
    dec_a_rx == rx_level[0]) else $error("decoder a wrong");
  AST_DEC_B: assert property (hold ##0 !rx_invalid[conn_mode == `MODE_SEG4 ? 2 : 1] |->
    dec_b_rx == rx_level[conn_mode == `MODE_SEG4 ? 2 : 1]) else $error("decoder b wrong");
  AST_AUX_IN: assert property (hold ##0 aux_sel_0 < `AUX_OUT_LO |->
    aux_oe_n[0] && aux_pull_up[0] == aux_sel_0[0]) else $error("aux input wrong");
  AST_AUX_ACT: assert property (hold ##0 aux_sel_0 >= `AUX_OUT_ACT1 && aux_sel_0 <= `AUX_OUT_ACT4
    |-> aux_out[0] == !rx_invalid[aux_sel_0 - `AUX_OUT_ACT1]) else $error("aux activity wrong");
  AST_AUX_DIR: assert property (hold ##0 aux_sel_1 == `AUX_OUT_DIR && conn_mode[0] &&
    ^rx_invalid[1:0] |-> aux_out[1] == rx_invalid[0]) else $error("aux direction wrong");
  AST_AUX_BUS: assert property (hold ##0 aux_sel_1 == `AUX_OUT_BUSACT && conn_mode[0] |->
    aux_out[1] == !(&rx_invalid[1:0])) else $error("aux bus activity wrong");
  AST_ERR_GO: assert property (|dec_error && aux_sel_0 == `AUX_OUT_ERR && $stable(aux_sel_0)
    |-> ##[1:3] aux_out[0]) else $error("error pulse missing");
  AST_ERR_LEN: assert property ($rose(aux_out[0]) && aux_sel_0 == `AUX_OUT_ERR &&
    bit_cycles == 16'h0004 |-> aux_out[0] [*4] ##1 !aux_out[0]) else $error("pulse length");
  // main scenarios reached
  cover property (hold ##0 conn_mode == `MODE_SEG2 && ^rx_invalid[1:0]);
  cover property ($rose(aux_out[0]) && aux_sel_0 == `AUX_OUT_ERR);
  cover property (rec_valid && !rec_ready);
endmodule // router_chk
bind bus_tap_signal_router router_chk #(.MODE_W(MODE_W), .SEL_W(SEL_W), .BIT_W(BIT_W)) chk_u (.*);

/* File: tb_top.sv */
// self-checking bench for the bus tap router, far side in bus_far_model
// inputs change at rising edges by nonblocking writes, checks 1 ns later
`timescale 1ns/1ns
`include "bus_tap_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module tb_top;
  reg clk_sys = 0, rst_n = 0, clk_en = 1, rec_ready = 1; // clock, reset, enable, sink ready
  reg [1:0] conn_mode = 0, dec_error = 0, aux_in = 2'h1; // mode, error pulses, aux levels
  reg [3:0] aux_sel_0 = 0, aux_sel_1 = 0, e; // aux selections, expected level
  reg [15:0] bit_cycles = 16'h0004; // short bit time keeps the run brief
  reg [10:0] tab = 11'h168; // aux level per selection, bus one-only, pairs one and three up
  wire [3:0] rx_level, rx_invalid, line_state, line_active;
  wire dec_a_rx, dec_b_rx, dir_val, dir_invalid, merged_val, merged_invalid, rec_valid;
  wire fwd_one_out, fwd_one_oe_n, fwd_two_out, fwd_two_oe_n;
  wire [1:0] aux_out, aux_oe_n, aux_pull_up, aux_rec;
  wire [31:0] rec_data;
  integer miscompares = 0, n_compared = 0, i, j, k, t0;
  always #4 clk_sys = ~clk_sys;
  bus_far_model far_u (.*);
  bus_tap_signal_router #(.STAMP_W(22)) dut_u (.*);
  // verdict and end of run
  task wrap_up;
    begin
      if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // new bus state and mode, then let the pipeline settle
  task go(input [3:0] d, input [3:0] l, input [1:0] m);
    begin
      @(posedge clk_sys);
      far_u.put(d, l);
      conn_mode <= m;
      repeat (8) @(posedge clk_sys);
      #1;
    end
  endtask
  // hang guard
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({dec_a_rx, dec_b_rx, dir_invalid, merged_invalid, aux_oe_n, rec_valid}, 7'h7E)
    @(posedge clk_sys);
    rst_n <= 1;
    go(4'hF, 4'hA, `MODE_TAP2);
    `CHK({line_active, line_state}, 8'hFA)
    go(4'h5, 4'hF, `MODE_TAP2);
    `CHK(line_active, 4'h5)
    `CHK(line_state & 4'h5, 4'h5)
    // every mode, two level patterns so idle never passes for data
    for (i = 0; i < 8; i++) begin
      e = i[0] ? 4'hA : 4'h5;
      go(4'hF, e, i[2:1]);
      `CHK(dec_a_rx, e[0])
      `CHK(dec_b_rx, (i[2:1] == `MODE_SEG4) ? e[2] : e[1])
    end
    go(4'h1, 4'h0, `MODE_SEG2);
    `CHK({dir_invalid, dir_val, merged_invalid, merged_val, fwd_two_oe_n, fwd_two_out}, 6'h0)
    `CHK({dec_a_rx, fwd_one_oe_n}, 2'h1)
    go(4'h2, 4'h2, `MODE_SEG2);
    `CHK({dir_invalid, dir_val, merged_invalid, merged_val, fwd_one_oe_n, fwd_one_out}, 6'h15)
    `CHK(dec_b_rx, 1'b1)
    go(4'h0, 4'h0, `MODE_SEG2);
    `CHK({dir_invalid, merged_invalid, fwd_one_oe_n, fwd_two_oe_n}, 4'hF)
    go(4'h6, 4'h6, `MODE_SEG4);
    `CHK({dir_val, dec_a_rx, dec_b_rx, fwd_one_oe_n}, 4'hE)
    // both aux pins through every selection except the error pulse, in opposite order
    go(4'h5, 4'h0, `MODE_SEG2);
    for (i = 0; i < 10; i++) begin
      j = 9 - i;
      @(posedge clk_sys);
      aux_sel_0 <= i[3:0];
      aux_sel_1 <= j[3:0];
      aux_in <= i[1:0];
      repeat (8) @(posedge clk_sys);
      #1;
      `CHK(aux_oe_n, {j < 2, i < 2})
      `CHK(aux_rec, aux_in)
      if (i > 1) `CHK(aux_out[0], tab[i])
      else `CHK({aux_pull_up[0], aux_rec[0]}, {i[0], aux_in[0]})
      if (j > 1) `CHK(aux_out[1], tab[j])
      else `CHK(aux_pull_up[1], j[0])
    end
    @(posedge clk_sys);
    aux_sel_0 <= `AUX_OUT_ERR;
    repeat (4) @(posedge clk_sys);
    dec_error <= 2'h2;
    @(posedge clk_sys);
    dec_error <= 2'h0;
    k = 0;
    repeat (12) begin
      @(posedge clk_sys);
      #1;
      k += aux_out[0];
    end
    `CHK(k, 4)
    // sink stalls while changes pile up, then drains
    go(4'hF, 4'h0, `MODE_TAP2);
    @(posedge clk_sys);
    rec_ready <= 0;
    for (i = 1; i < 11; i++) begin
      far_u.put(4'hF, i[3:0]);
      repeat (4) @(posedge clk_sys);
    end
    rec_ready <= 1;
    k = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (rec_valid === 1'b1) begin
        k++;
        t0 = rec_data[31:22];
      end
    end
    `CHK(k, 9)
    `CHK(t0[9:0], {aux_in, 8'hFA})
    // two changes 250 clocks apart are two microseconds apart
    @(posedge clk_sys);
    rec_ready <= 0;
    far_u.put(4'hF, 4'h1);
    repeat (250) @(posedge clk_sys);
    far_u.put(4'hF, 4'h2);
    repeat (8) @(posedge clk_sys);
    rec_ready <= 1;
    #1;
    t0 = rec_data[21:0];
    @(posedge clk_sys);
    #1;
    `CHK(rec_data[21:0] - t0[21:0], 22'h2)
    // enable low freezes the sampled state, enable high resumes it
    @(posedge clk_sys);
    clk_en <= 0;
    far_u.put(4'hF, 4'h5);
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK(line_state, 4'h2)
    @(posedge clk_sys);
    clk_en <= 1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(line_state, 4'h5)
    wrap_up;
  end
endmodule // tb_top
